// ===== logic/crtc_defs.vh
// Purpose: Constants for the calendar clock with alarm.
// Assumes: Byte-wide I/O bus, 200 MHz system clock.
// Notes:   Offsets are I/O byte addresses.
`ifndef CRTC_DEFS_VH
`define CRTC_DEFS_VH
`define CRTC_ADDR_W        16
`define CRTC_SEC_OFF       16'h00_E0
`define CRTC_MIN_OFF       16'h00_E1
`define CRTC_HRS_OFF       16'h00_E2
`define CRTC_WDAY_OFF      16'h00_E3
`define CRTC_MDAY_OFF      16'h00_E4
`define CRTC_MON_OFF       16'h00_E5
`define CRTC_YR_OFF        16'h00_E6
`define CRTC_CEN_OFF       16'h00_E7
`define CRTC_ASEC_OFF      16'h00_E8
`define CRTC_AMIN_OFF      16'h00_E9
`define CRTC_AHRS_OFF      16'h00_EA
`define CRTC_ADOW_OFF      16'h00_EB
`define CRTC_ACTRL_OFF     16'h00_EC
`define CRTC_CTRL_OFF      16'h00_ED
// Control register fields.
`define CRTC_CTRL_UNLOCK   0
`define CRTC_CTRL_SLOW     1
`define CRTC_CTRL_FREQ50   2
`define CRTC_CTRL_BCD      3
`define CRTC_CTRL_IRQEN    6
`define CRTC_CTRL_FLAG     7
// Alarm enable fields.
`define CRTC_AEN_SEC       0
`define CRTC_AEN_MIN       1
`define CRTC_AEN_HRS       2
`define CRTC_AEN_WDAY      3
// Source rates in ticks per second, then system clock in MHz and divider width.
`define CRTC_XTAL_HZ       32768
`define CRTC_LINE50_HZ     50
`define CRTC_LINE60_HZ     60
`define CRTC_CLK_MHZ       200
`define CRTC_DIV_W         16
`endif

// ===== logic/crtc_prescaler.v
// Purpose: Divides the selected count source down to one-second ticks.
// Assumes: Source edges arrive as one-cycle pulses synchronous to clk_in.
// Notes:   Clear restarts the division from zero.
`timescale 1ns/1ps
`include "crtc_defs.vh"
module crtc_prescaler #(
    parameter XTAL_HZ = `CRTC_XTAL_HZ
) (
    input  wire       clk_in,
    input  wire       srst_in,
    input  wire       clear_in,
    input  wire       run_in,
    input  wire       src_pulse_in,
    input  wire       line_in,
    input  wire       freq50_in,
    output reg        tick_out
);
    reg  [`CRTC_DIV_W-1:0] div_count;
    localparam [`CRTC_DIV_W-1:0] XTAL_LAST   = XTAL_HZ - 1;
    localparam [`CRTC_DIV_W-1:0] LINE50_LAST = `CRTC_LINE50_HZ - 1;
    localparam [`CRTC_DIV_W-1:0] LINE60_LAST = `CRTC_LINE60_HZ - 1;
    wire [`CRTC_DIV_W-1:0] div_last;
    assign div_last = !line_in ? XTAL_LAST : (freq50_in ? LINE50_LAST : LINE60_LAST);
    always @(posedge clk_in) begin
        tick_out <= 1'b0;
        if (srst_in || clear_in) begin
            div_count <= {`CRTC_DIV_W{1'b0}};
        end else if (run_in && src_pulse_in) begin
            if (div_count >= div_last) begin
                div_count <= {`CRTC_DIV_W{1'b0}};
                tick_out  <= 1'b1;
            end else begin
                div_count <= div_count + 1'b1;
            end
        end
    end
endmodule // crtc_prescaler

// ===== logic/crtc_field.v
// Purpose: One count field with rollover in binary or packed BCD.
// Assumes: Limits are given in binary.
// Notes:   Out-of-range loaded values still roll over at the limit.
`timescale 1ns/1ps
module crtc_field #(
    parameter MIN_VAL = 0
) (
    input  wire [7:0] value_in,
    input  wire [7:0] max_in,
    input  wire       bcd_in,
    output reg  [7:0] next_out,
    output reg        wrap_out
);
    function [7:0] to_bin;
        input [7:0] v;
        input       b;
        begin
            to_bin = b ? v[7:4] * 8'd10 + {4'h0, v[3:0]} : v;
        end
    endfunction
    function [7:0] to_bcd;
        input [7:0] v;
        reg   [7:0] tens;
        reg   [7:0] units;
        begin
            tens   = v / 8'd10;
            units  = v % 8'd10;
            to_bcd = {tens[3:0], units[3:0]};
        end
    endfunction
    localparam [7:0] MIN_BYTE = MIN_VAL;
    reg [7:0] bin_val;
    always @* begin
        bin_val  = to_bin(value_in, bcd_in);
        wrap_out = (bin_val >= max_in);
        if (wrap_out) begin
            bin_val = MIN_BYTE;
        end else begin
            bin_val = bin_val + 8'h01;
        end
        next_out = bcd_in ? to_bcd(bin_val) : bin_val;
    end
endmodule // crtc_field

// ===== logic/crtc_top.v
// What this block does
// R1: Counts seconds, minutes, hours, weekday, monthday, month, year, century in 24-hour form.
// R2: Counts and alarm set-points are binary or packed BCD by the format bit.
// R3: Month lengths are kept and February gains its leap day automatically.
// R4: Alarm fires only when every enabled set-point equals its count.
// R5: An alarm with interrupt enable set raises the interrupt request.
// R6: Reading the control register clears the match flag and interrupt.
// R7: Alarm set-points and enables are writable at any time.
// R8: Alarm comparison runs whenever the count advances, once per second.
// R9: Writing zero to the unlock bit forces an immediate alarm comparison.
// R10: Count source is the crystal or line input, divided to one-second ticks.
// R11: Any write to the control register resets the prescaler.
// R12: After power-loss reset counts are undefined and alarm enables cleared.
// R13: Software unlocks, loads counts, loads alarms, then locks again.
// R14: Clearing the unlock bit resets the prescaler and lets it run.
// R15: Unlocked stops counting and allows count writes; locked counts, ignores writes.
// R16: Reset leaves the counter locked and counting.
// R17: Reset leaves the seconds and minutes counts unchanged.
// R18: Seconds hold tens 0-5 and units 0-9, or binary 00h-3Bh.
// R19: Minutes hold tens 0-5 and units, or binary 00h-3Bh.
// R20: All registers are reached by I/O reads and writes on the bus.
// R21: Hours run 0 to 23, BCD tens 0-2 or binary up to 17h.
// R22: Weekday uses bits 3:0 with values 1 to 7; upper bits read zero.
// R23: Monthday starts at one, BCD tens 0-3 or binary up to 1Fh.
// R24: Year is two BCD digits or binary up to 63h and wraps into century.
// R25: Each field rolls to its minimum and carries into the next.
// R26: Locked count writes are ignored and never disturb counting.
// R27: The match flag stays set until the control register is read.
//
// Purpose: Calendar real-time clock with alarm on a byte-wide I/O bus.
// Assumes: Bus strobes are one-cycle pulses; source pulses synchronous to clk_in.
// Notes:   Count registers have no reset, so they survive a system reset.
`timescale 1ns/1ps
`include "crtc_defs.vh"
module crtc_top #(
    parameter XTAL_HZ = `CRTC_XTAL_HZ
) (
    input  wire                    clk_in,
    input  wire                    srst_in,
    input  wire [`CRTC_ADDR_W-1:0] io_addr_in,
    input  wire [7:0]              io_wdata_in,
    input  wire                    io_wr_in,
    input  wire                    io_rd_in,
    input  wire                    xtal_pulse_in,
    input  wire                    crystal_out_pin_pulse_in,
    output reg  [7:0]              io_rdata_out,
    output reg                     irq_out
);
    // Counts; deliberately left without reset.
    reg [7:0] elapsed_ticks_register; // [R17]
    reg [7:0] minutes_count;
    reg [7:0] hours_count;
    reg [3:0] weekday_count;
    reg [7:0] monthday_count;
    reg [7:0] month_count;
    reg [7:0] year_count;
    reg [7:0] century_count;
    reg [7:0] alarm_sec;
    reg [7:0] alarm_min;
    reg [7:0] alarm_hrs;
    reg [3:0] alarm_wday;
    reg [3:0] alarm_enable;
    reg       count_write_unlock;
    reg       count_source_select;
    reg       line_freq50;
    reg       decimal_format_select;
    reg       alarm_irq_enable;
    reg       match_event_flag;
    reg       compare_now;

    wire wr_ctrl;
    wire rd_ctrl;
    wire cnt_wr;
    wire sec_tick;
    wire src_pulse;
    assign wr_ctrl   = io_wr_in && (io_addr_in == `CRTC_CTRL_OFF);                       // [R20]
    assign rd_ctrl   = io_rd_in && (io_addr_in == `CRTC_CTRL_OFF);
    assign cnt_wr    = io_wr_in && count_write_unlock;                                   // [R15] [R26]
    assign src_pulse = count_source_select ? crystal_out_pin_pulse_in : xtal_pulse_in;  // [R10]

    crtc_prescaler #(.XTAL_HZ(XTAL_HZ)) u_presc (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .clear_in     (wr_ctrl),                                                          // [R11] [R14]
        .run_in       (!count_write_unlock),
        .src_pulse_in (src_pulse),
        .line_in      (count_source_select),
        .freq50_in    (line_freq50),
        .tick_out     (sec_tick)
    );

    function is_leap;
        input [7:0] yr;
        input [7:0] cen;
        input       b;
        reg   [7:0] y;
        reg   [7:0] c;
        begin
            y = b ? yr[7:4] * 8'd10 + {4'h0, yr[3:0]} : yr;
            c = b ? cen[7:4] * 8'd10 + {4'h0, cen[3:0]} : cen;
            is_leap = (y[1:0] == 2'b00) && ((y != 8'd0) || (c[1:0] == 2'b00));
        end
    endfunction

    function [7:0] month_days;
        input [7:0] mon;
        input       leap;
        input       b;
        reg   [7:0] m;
        begin
            m = b ? mon[7:4] * 8'd10 + {4'h0, mon[3:0]} : mon;
            case (m)
                8'd2:                       month_days = leap ? 8'd29 : 8'd28;
                8'd4, 8'd6, 8'd9, 8'd11:    month_days = 8'd30;
                default:                    month_days = 8'd31;
            endcase
        end
    endfunction

    wire [7:0] next_sec, next_min, next_hrs, next_wday, next_mday, next_mon, next_yr, next_cen;
    wire       w_sec, w_min, w_hrs, w_mday, w_mon, w_yr;
    wire [7:0] mday_max;
    wire       bcd;
    assign bcd     = decimal_format_select;                                               // [R2]
    assign mday_max = month_days(month_count, is_leap(year_count, century_count, bcd), bcd); // [R3]

    crtc_field #(.MIN_VAL(0)) u_sec ( // [R18]
        .value_in (elapsed_ticks_register),
        .max_in   (8'h3B),
        .bcd_in   (bcd),
        .next_out (next_sec),
        .wrap_out (w_sec)
    );
    crtc_field #(.MIN_VAL(0)) u_min ( // [R19]
        .value_in (minutes_count),
        .max_in   (8'h3B),
        .bcd_in   (bcd),
        .next_out (next_min),
        .wrap_out (w_min)
    );
    crtc_field #(.MIN_VAL(0)) u_hrs ( // [R21]
        .value_in (hours_count),
        .max_in   (8'h17),
        .bcd_in   (bcd),
        .next_out (next_hrs),
        .wrap_out (w_hrs)
    );
    // Weekday is a single digit, so it counts in hex whatever the format bit says.
    crtc_field #(.MIN_VAL(1)) u_wday ( // [R22]
        .value_in ({4'h0, weekday_count}),
        .max_in   (8'h07),
        .bcd_in   (1'b0),
        .next_out (next_wday),
        .wrap_out ()
    );
    crtc_field #(.MIN_VAL(1)) u_mday ( // [R23]
        .value_in (monthday_count),
        .max_in   (mday_max),
        .bcd_in   (bcd),
        .next_out (next_mday),
        .wrap_out (w_mday)
    );
    crtc_field #(.MIN_VAL(1)) u_mon (
        .value_in (month_count),
        .max_in   (8'h0C),
        .bcd_in   (bcd),
        .next_out (next_mon),
        .wrap_out (w_mon)
    );
    crtc_field #(.MIN_VAL(0)) u_yr ( // [R24]
        .value_in (year_count),
        .max_in   (8'h63),
        .bcd_in   (bcd),
        .next_out (next_yr),
        .wrap_out (w_yr)
    );
    crtc_field #(.MIN_VAL(0)) u_cen (
        .value_in (century_count),
        .max_in   (8'h63),
        .bcd_in   (bcd),
        .next_out (next_cen),
        .wrap_out ()
    );

    // Counting and locked-out writes never meet: writes need unlock, ticks need lock.
    always @(posedge clk_in) begin
        if (sec_tick) begin                                                               // [R1] [R25]
            elapsed_ticks_register <= next_sec;
            if (w_sec) begin
                minutes_count <= next_min;
                if (w_min) begin
                    hours_count <= next_hrs;
                    if (w_hrs) begin
                        weekday_count  <= next_wday[3:0];
                        monthday_count <= next_mday;
                        if (w_mday) begin
                            month_count <= next_mon;
                            if (w_mon) begin
                                year_count <= next_yr;
                                if (w_yr) begin
                                    century_count <= next_cen;
                                end
                            end
                        end
                    end
                end
            end
        end else if (cnt_wr) begin                                                        // [R15]
            case (io_addr_in)
                `CRTC_SEC_OFF: elapsed_ticks_register <= io_wdata_in;
                `CRTC_MIN_OFF: minutes_count  <= io_wdata_in;
                `CRTC_HRS_OFF: hours_count    <= io_wdata_in;
                `CRTC_WDAY_OFF: weekday_count  <= io_wdata_in[3:0];
                `CRTC_MDAY_OFF: monthday_count <= io_wdata_in;
                `CRTC_MON_OFF: month_count    <= io_wdata_in;
                `CRTC_YR_OFF:  year_count     <= io_wdata_in;
                `CRTC_CEN_OFF: century_count  <= io_wdata_in;
                default: ;
            endcase
        end
    end

    // Alarm set-points carry no reset and are writable whether locked or not.
    always @(posedge clk_in) begin
        if (io_wr_in) begin                                                               // [R7]
            case (io_addr_in)
                `CRTC_ASEC_OFF: alarm_sec <= io_wdata_in;
                `CRTC_AMIN_OFF: alarm_min <= io_wdata_in;
                `CRTC_AHRS_OFF: alarm_hrs <= io_wdata_in;
                `CRTC_ADOW_OFF: alarm_wday <= io_wdata_in[3:0];
                default: ;
            endcase
        end
    end

    wire alarm_hit;
    assign alarm_hit = (!alarm_enable[`CRTC_AEN_SEC] || alarm_sec == elapsed_ticks_register) &&
                       (!alarm_enable[`CRTC_AEN_MIN] || alarm_min == minutes_count) &&
                       (!alarm_enable[`CRTC_AEN_HRS] || alarm_hrs == hours_count) &&
                       (!alarm_enable[`CRTC_AEN_WDAY] || alarm_wday == weekday_count) &&
                       (alarm_enable != 4'h0);                                            // [R4]

    always @(posedge clk_in) begin
        if (srst_in) begin
            alarm_enable          <= 4'h0;                                                // [R12]
            count_write_unlock    <= 1'b0;                                                // [R16]
            count_source_select   <= 1'b0;
            line_freq50           <= 1'b0;
            decimal_format_select <= 1'b0;
            alarm_irq_enable      <= 1'b0;
            match_event_flag      <= 1'b0;
            compare_now           <= 1'b0;
            irq_out               <= 1'b0;
        end else begin
            // Comparison uses the counts one cycle after they advanced.
            compare_now <= sec_tick || (wr_ctrl && !io_wdata_in[`CRTC_CTRL_UNLOCK]);      // [R8] [R9]
            if (io_wr_in && io_addr_in == `CRTC_ACTRL_OFF) begin
                alarm_enable <= io_wdata_in[3:0];                                         // [R7]
            end
            if (wr_ctrl) begin
                count_write_unlock    <= io_wdata_in[`CRTC_CTRL_UNLOCK];                  // [R14] [R15]
                count_source_select   <= io_wdata_in[`CRTC_CTRL_SLOW];                    // [R10]
                line_freq50           <= io_wdata_in[`CRTC_CTRL_FREQ50];
                decimal_format_select <= io_wdata_in[`CRTC_CTRL_BCD];                     // [R2]
                alarm_irq_enable      <= io_wdata_in[`CRTC_CTRL_IRQEN];
            end
            // A match in the same cycle as the clearing read wins.
            if (compare_now && alarm_hit) begin
                match_event_flag <= 1'b1;                                                 // [R27]
            end else if (rd_ctrl) begin
                match_event_flag <= 1'b0;                                                 // [R6]
            end
            if (compare_now && alarm_hit && alarm_irq_enable) begin
                irq_out <= 1'b1;                                                          // [R5]
            end else if (rd_ctrl || !alarm_irq_enable) begin
                irq_out <= 1'b0;                                                          // [R6]
            end
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            io_rdata_out <= 8'h00;
        end else if (io_rd_in) begin                                                      // [R20]
            case (io_addr_in)
                `CRTC_SEC_OFF:   io_rdata_out <= elapsed_ticks_register;
                `CRTC_MIN_OFF:   io_rdata_out <= minutes_count;
                `CRTC_HRS_OFF:   io_rdata_out <= hours_count;
                `CRTC_WDAY_OFF:  io_rdata_out <= {4'h0, weekday_count}; // [R22]
                `CRTC_MDAY_OFF:  io_rdata_out <= monthday_count;
                `CRTC_MON_OFF:   io_rdata_out <= month_count;
                `CRTC_YR_OFF:    io_rdata_out <= year_count;
                `CRTC_CEN_OFF:   io_rdata_out <= century_count;
                `CRTC_ASEC_OFF:  io_rdata_out <= alarm_sec;
                `CRTC_AMIN_OFF:  io_rdata_out <= alarm_min;
                `CRTC_AHRS_OFF:  io_rdata_out <= alarm_hrs;
                `CRTC_ADOW_OFF:  io_rdata_out <= {4'h0, alarm_wday};
                `CRTC_ACTRL_OFF: io_rdata_out <= {4'h0, alarm_enable};
                `CRTC_CTRL_OFF:  io_rdata_out <= {match_event_flag, alarm_irq_enable, 2'b00, decimal_format_select,
                                                  line_freq50, count_source_select, count_write_unlock};
                default:         io_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // crtc_top

// ===== verif/crtc_properties.sv
// Purpose: Port-level checks for the calendar clock with alarm.
// Assumes: Strobes are one-cycle pulses from a single bus master.
// Notes:   A quiet counter hides the few cycles in which a tick or a forced compare may still set the flag.
`timescale 1ns/1ps
`include "crtc_defs.vh"
module crtc_properties #(
    parameter XTAL_HZ = 4
) (
    input wire logic                    clk_in,
    input wire logic                    srst_in,
    input wire logic [`CRTC_ADDR_W-1:0] io_addr_in,
    input wire logic [7:0]              io_wdata_in,
    input wire logic                    io_wr_in,
    input wire logic                    io_rd_in,
    input wire logic                    xtal_pulse_in,
    input wire logic                    crystal_out_pin_pulse_in,
    input wire logic [7:0]              io_rdata_out,
    input wire logic                    irq_out
);
    logic [3:0] quiet_cnt;
    wire        ctrl_rd = io_rd_in && (io_addr_in == `CRTC_CTRL_OFF);
    wire        ctrl_wr = io_wr_in && (io_addr_in == `CRTC_CTRL_OFF);
    wire        mapped  = (io_addr_in >= `CRTC_SEC_OFF) && (io_addr_in <= `CRTC_CTRL_OFF);
    always_ff @(posedge clk_in) begin
        if (srst_in || io_wr_in || xtal_pulse_in || crystal_out_pin_pulse_in) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    AST_RESET_OUTPUTS: assert property ($past(srst_in) |-> !irq_out && io_rdata_out == 8'h00)
        else $error("outputs not cleared by reset");
    AST_UNMAPPED_READ_ZERO: assert property (io_rd_in && !mapped |=> io_rdata_out == 8'h00)
        else $error("unmapped read returned data");
    AST_RDATA_HOLDS: assert property (!io_rd_in |=> $stable(io_rdata_out))
        else $error("read data moved without a read");
    AST_CTRL_READ_CLEARS: assert property (ctrl_rd && quiet_cnt >= 4'h8 |=> !irq_out)
        else $error("control read left the interrupt up");
    AST_IRQ_STICKY: assert property (irq_out && !ctrl_rd && !ctrl_wr && !$past(ctrl_wr) |=> irq_out)
        else $error("interrupt dropped without a control access");
    AST_IRQ_NEEDS_EVENT: assert property ($rose(irq_out) |-> quiet_cnt < 4'h8)
        else $error("interrupt rose with no tick or forced compare");
    AST_WEEKDAY_UPPER_ZERO: assert property (io_rd_in && io_addr_in == `CRTC_WDAY_OFF |=> io_rdata_out[7:4] == 4'h0)
        else $error("weekday upper bits not zero");
    AST_SEC_RANGE: assert property (io_rd_in && io_addr_in == `CRTC_SEC_OFF |=> io_rdata_out[7:4] <= 4'h5)
        else $error("seconds out of range");
    AST_MIN_RANGE: assert property (io_rd_in && io_addr_in == `CRTC_MIN_OFF |=> io_rdata_out[7:4] <= 4'h5)
        else $error("minutes out of range");
    AST_HRS_RANGE: assert property (io_rd_in && io_addr_in == `CRTC_HRS_OFF |=> io_rdata_out <= 8'h23)
        else $error("hours out of range");
    COV_IRQ_RISE: cover property ($rose(irq_out));
    COV_CTRL_CLEAR: cover property (ctrl_rd && irq_out ##1 !irq_out);
    COV_UNMAPPED: cover property (io_rd_in && !mapped);
endmodule // crtc_properties
bind crtc_top crtc_properties #(.XTAL_HZ(XTAL_HZ)) i_crtc_properties (.clk_in(clk_in), .srst_in(srst_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .xtal_pulse_in(xtal_pulse_in), .crystal_out_pin_pulse_in(crystal_out_pin_pulse_in),
    .io_rdata_out(io_rdata_out), .irq_out(irq_out));

// ===== verif/crtc_cpu_model.sv
// Purpose: Bus master standing in for the processor on the I/O bus.
// Assumes: Signals change at the falling edge and stand over one rising edge.
// Notes:   Idle address and data show the inverse of the last value so stale bytes never look valid.
`timescale 1ns/1ps
module crtc_cpu_model (
    input  wire logic        clk_in,
    input  wire logic [7:0]  io_rdata_in,
    output logic      [15:0] io_addr_out,
    output logic      [7:0]  io_wdata_out,
    output logic             io_wr_out,
    output logic             io_rd_out
);
    initial begin
        io_addr_out = 16'h0000;
        io_wdata_out = 8'h00;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        io_addr_out = a;
        io_wdata_out = d;
        io_wr_out = 1'b1;
        @(negedge clk_in);
        io_wr_out = 1'b0;
        io_addr_out = ~a;
        io_wdata_out = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_in);
        io_addr_out = a;
        io_rd_out = 1'b1;
        @(negedge clk_in);
        d = io_rdata_in;
        io_rd_out = 1'b0;
        io_addr_out = ~a;
    endtask
endmodule // crtc_cpu_model

// ===== verif/crtc_top_bench.sv
// Purpose: Self-checking bench for the calendar clock with alarm.
// Assumes: The divider is shortened to four crystal pulses per second.
// Notes:   Count registers are loaded before any read, since reset leaves them unknown.
`timescale 1ns/1ps
`include "crtc_defs.vh"
module crtc_top_bench;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        xtal = 1'b0;
    logic        line = 1'b0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    wire  [15:0] addr;
    wire  [7:0]  wdata;
    wire  [7:0]  rdata;
    wire         wr_s;
    wire         rd_s;
    wire         irq;
    crtc_top #(.XTAL_HZ(4)) i_crtc_top (.clk_in(clk_in), .srst_in(srst_in), .io_addr_in(addr),
        .io_wdata_in(wdata), .io_wr_in(wr_s), .io_rd_in(rd_s), .xtal_pulse_in(xtal),
        .crystal_out_pin_pulse_in(line), .io_rdata_out(rdata), .irq_out(irq));
    crtc_cpu_model i_crtc_cpu_model (.clk_in(clk_in), .io_rdata_in(rdata), .io_addr_out(addr),
        .io_wdata_out(wdata), .io_wr_out(wr_s), .io_rd_out(rd_s));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: interrupt %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_crtc_cpu_model.wr(a, d);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_crtc_cpu_model.rd(a, d);
        chk_byte(d, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic pulses(input logic use_line, input int n);
        repeat (n) begin
            @(negedge clk_in);
            xtal <= !use_line;
            line <= use_line;
            @(negedge clk_in);
            xtal <= 1'b0;
            line <= 1'b0;
        end
        idle(8);
    endtask
    // Unlock, load, let pulses pass while stopped, lock, then one second of pulses.
    task automatic run_case(input logic [7:0] fmt, input logic [63:0] ini, input logic [63:0] exp);
        wr(`CRTC_CTRL_OFF, fmt | 8'h01);
        for (int i = 0; i < 8; i++) wr(`CRTC_SEC_OFF + 16'(i), ini[63-8*i -: 8]);
        pulses(1'b0, 8);
        wr(`CRTC_CTRL_OFF, fmt);
        pulses(1'b0, 4);
        for (int i = 0; i < 8; i++) chk_read(i, exp[63-8*i -: 8]);
    endtask
    task automatic chk_read(input int i, input logic [7:0] e);
        rdc(`CRTC_SEC_OFF + 16'(i), e);
    endtask
    initial begin
        idle(20);
        srst_in <= 1'b0;
        idle(1);
        rdc(`CRTC_CTRL_OFF, 8'h00);
        rdc(`CRTC_ACTRL_OFF, 8'h00);
        rdc(16'h00_F0, 8'h00);
        run_case(8'h00, 64'h3B3B_1703_1F0C_6314, 64'h0000_0004_0101_0015);
        run_case(8'h08, 64'h5959_2307_3112_9919, 64'h0000_0001_0101_0020);
        run_case(8'h00, 64'h3B3B_1701_1C02_0514, 64'h0000_0002_0103_0514);
        run_case(8'h00, 64'h3B3B_1707_1C02_0414, 64'h0000_0001_1D02_0414);
        wr(`CRTC_SEC_OFF, 8'h10);
        rdc(`CRTC_SEC_OFF, 8'h00);
        wr(`CRTC_ASEC_OFF, 8'h01);
        wr(`CRTC_ACTRL_OFF, 8'h01);
        wr(`CRTC_CTRL_OFF, 8'h40);
        idle(4);
        rdc(`CRTC_CTRL_OFF, 8'h40);
        pulses(1'b0, 4);
        chk_bit(irq, 1'b1);
        idle(20);
        chk_bit(irq, 1'b1);
        rdc(`CRTC_CTRL_OFF, 8'hC0);
        chk_bit(irq, 1'b0);
        wr(`CRTC_AMIN_OFF, 8'h00);
        wr(`CRTC_ADOW_OFF, 8'h01);
        wr(`CRTC_ACTRL_OFF, 8'h0B);
        wr(`CRTC_CTRL_OFF, 8'h40);
        idle(4);
        rdc(`CRTC_CTRL_OFF, 8'hC0);
        wr(`CRTC_AHRS_OFF, 8'h05);
        wr(`CRTC_ACTRL_OFF, 8'h0F);
        wr(`CRTC_CTRL_OFF, 8'h40);
        idle(4);
        rdc(`CRTC_CTRL_OFF, 8'h40);
        wr(`CRTC_ACTRL_OFF, 8'h01);
        wr(`CRTC_CTRL_OFF, 8'h00);
        idle(4);
        chk_bit(irq, 1'b0);
        rdc(`CRTC_CTRL_OFF, 8'h80);
        wr(`CRTC_ACTRL_OFF, 8'h00);
        pulses(1'b0, 3);
        wr(`CRTC_CTRL_OFF, 8'h00);
        pulses(1'b0, 3);
        rdc(`CRTC_SEC_OFF, 8'h01);
        pulses(1'b0, 1);
        rdc(`CRTC_SEC_OFF, 8'h02);
        wr(`CRTC_CTRL_OFF, 8'h02);
        pulses(1'b1, 59);
        rdc(`CRTC_SEC_OFF, 8'h02);
        pulses(1'b1, 1);
        rdc(`CRTC_SEC_OFF, 8'h03);
        wr(`CRTC_CTRL_OFF, 8'h06);
        pulses(1'b1, 50);
        rdc(`CRTC_SEC_OFF, 8'h04);
        wr(`CRTC_CTRL_OFF, 8'h01);
        wr(`CRTC_MIN_OFF, 8'h2A);
        srst_in <= 1'b1;
        idle(3);
        srst_in <= 1'b0;
        idle(1);
        rdc(`CRTC_SEC_OFF, 8'h04);
        rdc(`CRTC_MIN_OFF, 8'h2A);
        rdc(`CRTC_CTRL_OFF, 8'h00);
        rdc(`CRTC_ACTRL_OFF, 8'h00);
        end_sim;
    end
    // The tests need some seven hundred and fifty cycles; this leaves ample margin.
    initial begin
        repeat (30000) @(posedge clk_in);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim;
    end
endmodule // crtc_top_bench
